// ---- core/scss_top.sv ----
// module: card-side session sequencer with avalon register slave
`timescale 1ns/1ns
// Behaviour
// - barred dialling rehab needs call control
// - invalidate both files after selection
// - both dialling enabled rejects fdn-only rehab
// - card may change idle polling interval
// - denied read returns error, no data
module scss_top
  import scss_pkg::*;
#(
  parameter int unsigned POLL_DEF = 30
) (
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_N_I,
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS_I,
  input  wire logic                AVS_READ_I,
  input  wire logic                AVS_WRITE_I,
  input  wire logic [31:0]         AVS_WRITEDATA_I,
  output logic      [31:0]         AVS_READDATA_O,
  output logic                     AVS_WAITREQUEST_O,
  output logic                     AVS_RESPONSE_ERR_O
);

  if (POLL_DEF == 0 || POLL_DEF > 255) begin : g_chk
    $error("POLL_DEF out of range");
  end

  typedef struct packed {
    scss_fsm_e           fsm;
    logic [CTRL_W-1:0]   ctrl;
    logic                ident_valid;
    logic                loc_valid;
    logic                prof_seen;
    logic [1:0]          prof;
    logic                sel_pend;
    logic [7:0]          result;
    logic [7:0]          data;
    logic [7:0]          poll_ivl;
    logic [31:0]         rdata;
    logic                err;
    scss_cmd_s           cmd;
  } scss_state_s;

  scss_state_s   s_q;
  scss_state_s   s_d;
  scss_bus_req_s bus;
  logic          rehab_ok;
  logic          read_ok;

  function automatic logic is_id_file(input logic [7:0] f);
    is_id_file = (f == FILE_IDENT) || (f == FILE_LOC);
  endfunction : is_id_file

  assign bus = '{read: AVS_READ_I, write: AVS_WRITE_I,
                 address: AVS_ADDRESS_I, writedata: AVS_WRITEDATA_I};

  scss_gate u_gate (
    .fdn_en_i      (s_q.ctrl[CTRL_FDN_EN]),
    .bdn_en_i      (s_q.ctrl[CTRL_BDN_EN]),
    .prof_fdn_i    (s_q.prof[PROF_FDN]),
    .prof_cc_i     (s_q.prof[PROF_CC]),
    .prof_seen_i   (s_q.prof_seen),
    .ident_valid_i (s_q.ident_valid && !s_q.sel_pend),
    .loc_valid_i   (s_q.loc_valid && !s_q.sel_pend),
    .rehab_ok_o    (rehab_ok),
    .read_ok_o     (read_ok)
  );

  always_comb begin
    s_d = s_q;
    case (s_q.fsm)
      ST_IDLE: begin
        if (bus.read || bus.write) begin
          s_d.fsm = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_d.fsm = ST_DONE;
        s_d.err = 1'b0;
        if (bus.read) begin
          case (bus.address)
            REG_CTRL:   s_d.rdata = {{(32-CTRL_W){1'b0}}, s_q.ctrl};
            REG_STATUS: s_d.rdata = {26'h000_0000, s_q.sel_pend, s_q.prof_seen,
                                     s_q.prof[PROF_FDN], s_q.prof[PROF_CC],
                                     s_q.loc_valid, s_q.ident_valid};
            REG_REQ:    s_d.rdata = {16'h0000, s_q.poll_ivl, s_q.data};
            REG_RESULT: s_d.rdata = {24'h00_0000, s_q.result};
            default: begin
              s_d.rdata = 32'h0000_0000;
              s_d.err   = 1'b1;
            end
          endcase
        end else begin
          s_d.rdata = 32'h0000_0000;
          case (bus.address)
            REG_CTRL: s_d.ctrl = bus.writedata[CTRL_W-1:0];
            REG_REQ: begin
              s_d.cmd.kind = bus.writedata[REQ_KIND_LSB +: REQ_KIND_W];
              s_d.cmd.arg  = bus.writedata[REQ_ARG_LSB +: REQ_ARG_W];
              // any command after a selection invalidates
              if (s_q.sel_pend) begin
                s_d.ident_valid = 1'b0;
                s_d.loc_valid   = 1'b0;
                s_d.sel_pend    = 1'b0;
              end
              s_d.result = RES_OK;
              case (s_d.cmd.kind)
                REQ_SELECT: begin
                  if (s_q.ctrl[CTRL_USES_DN] && is_id_file(s_d.cmd.arg)) begin
                    s_d.sel_pend = 1'b1;
                  end
                end
                REQ_READ: begin
                  if (is_id_file(s_d.cmd.arg) && !read_ok) begin
                    s_d.result = RES_ACCESS_ERR;
                    s_d.data   = 8'h00;
                  end else begin
                    s_d.data = s_d.cmd.arg;
                  end
                end
                REQ_PROFILE: begin
                  s_d.prof      = s_d.cmd.arg[1:0];
                  s_d.prof_seen = 1'b1;
                end
                REQ_REHAB: begin
                  if (rehab_ok) begin
                    s_d.ident_valid = 1'b1;
                    s_d.loc_valid   = 1'b1;
                    s_d.sel_pend    = 1'b0;
                  end else begin
                    s_d.result = RES_REHAB_ERR;
                  end
                end
                REQ_STATUS: begin
                  // nonzero argument sets idle poll interval
                  if (s_d.cmd.arg != 8'h00) begin
                    s_d.poll_ivl = s_d.cmd.arg;
                  end
                  s_d.data = s_q.poll_ivl;
                end
                default: s_d.result = RES_BAD_REQ;
              endcase
            end
            REG_STATUS, REG_RESULT: ;
            default: s_d.err = 1'b1;
          endcase
        end
      end
      ST_DONE: s_d.fsm = ST_IDLE;
      default: s_d.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      s_q          <= '0;
      s_q.fsm      <= ST_IDLE;
      s_q.ctrl     <= CTRL_RESET;
      s_q.ident_valid <= 1'b1;
      s_q.loc_valid   <= 1'b1;
      s_q.poll_ivl <= 8'(POLL_DEF);
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_WAITREQUEST_O  = (bus.read || bus.write) && (s_q.fsm != ST_DONE);
  assign AVS_READDATA_O     = s_q.rdata;
  assign AVS_RESPONSE_ERR_O = s_q.err;

endmodule : scss_top

// ---- core/scss_pkg.sv ----
// package: constants and carriers for the card session sequencer
package scss_pkg;

  localparam int unsigned ADDR_W = 4;

  // register word offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_REQ    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'hC;

  // control field positions
  localparam int unsigned CTRL_FDN_EN  = 0;
  localparam int unsigned CTRL_BDN_EN  = 1;
  localparam int unsigned CTRL_USES_DN = 2;
  localparam int unsigned CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // request register fields
  localparam int unsigned REQ_KIND_LSB = 0;
  localparam int unsigned REQ_KIND_W   = 3;
  localparam int unsigned REQ_ARG_LSB  = 4;
  localparam int unsigned REQ_ARG_W    = 8;

  // status field positions
  localparam int unsigned ST_IDENT_VALID = 0;
  localparam int unsigned ST_LOC_VALID   = 1;
  localparam int unsigned ST_CC_SUPP     = 2;
  localparam int unsigned ST_FDN_SUPP    = 3;
  localparam int unsigned ST_PROFILE     = 4;
  localparam int unsigned ST_SEL_PEND    = 5;

  // result codes
  localparam logic [7:0] RES_OK         = 8'h00;
  localparam logic [7:0] RES_ACCESS_ERR = 8'h01;
  localparam logic [7:0] RES_REHAB_ERR  = 8'h02;
  localparam logic [7:0] RES_BAD_REQ    = 8'h03;

  // profile bits
  localparam int unsigned PROF_FDN = 0;
  localparam int unsigned PROF_CC  = 1;

  // file ids carried in the argument field
  localparam logic [7:0] FILE_IDENT = 8'h01;
  localparam logic [7:0] FILE_LOC   = 8'h02;

  typedef enum logic [2:0] {
    REQ_SELECT  = 3'h1,
    REQ_READ    = 3'h2,
    REQ_PROFILE = 3'h3,
    REQ_REHAB   = 3'h4,
    REQ_STATUS  = 3'h5
  } scss_req_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } scss_fsm_e;

  typedef struct packed {
    logic                 read;
    logic                 write;
    logic [ADDR_W-1:0]    address;
    logic [31:0]          writedata;
  } scss_bus_req_s;

  typedef struct packed {
    logic [REQ_KIND_W-1:0] kind;
    logic [REQ_ARG_W-1:0]  arg;
  } scss_cmd_s;

endpackage : scss_pkg

// ---- core/scss_gate.sv ----
// module: access and rehabilitation gate for identity and location files
`timescale 1ns/1ns
module scss_gate
  import scss_pkg::*;
(
  input  wire logic  fdn_en_i,
  input  wire logic  bdn_en_i,
  input  wire logic  prof_fdn_i,
  input  wire logic  prof_cc_i,
  input  wire logic  prof_seen_i,
  input  wire logic  ident_valid_i,
  input  wire logic  loc_valid_i,
  output logic       rehab_ok_o,
  output logic       read_ok_o
);

  always_comb begin
    rehab_ok_o = 1'b1;
    if (bdn_en_i && !(prof_seen_i && prof_cc_i)) begin
      rehab_ok_o = 1'b0;
    end
    // both enabled, fdn without call control
    if (fdn_en_i && bdn_en_i && prof_fdn_i && !prof_cc_i) begin
      rehab_ok_o = 1'b0;
    end
    read_ok_o = ident_valid_i && loc_valid_i;
  end

endmodule : scss_gate

// ---- tb/scss_checker.sv ----
// checker: answer timing and refusals on the register port
`timescale 1ns/1ns
module scss_checker
  import scss_pkg::*;
(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [31:0]       AVS_READDATA_O,
  input  wire logic              AVS_WAITREQUEST_O,
  input  wire logic              AVS_RESPONSE_ERR_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire req = AVS_READ_I || AVS_WRITE_I;
  wire ans = req && !AVS_WAITREQUEST_O;
  wire rda = ans && AVS_READ_I;
  wire odd = AVS_ADDRESS_I[1:0] != 2'b00;
  two_waits_a: assert property ($rose(req) |-> AVS_WAITREQUEST_O [*2] ##1 !AVS_WAITREQUEST_O)
    else $error("answer not after two wait cycles");
  no_req_wait_a: assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("wait raised without request");
  unmapped_err_a: assert property (ans |-> AVS_RESPONSE_ERR_O == odd)
    else $error("error flag wrong for address");
  unmapped_zero_a: assert property (rda && odd |-> AVS_READDATA_O == '0)
    else $error("unmapped read returned data");
  ctrl_upper_a: assert property (rda && AVS_ADDRESS_I == REG_CTRL |-> AVS_READDATA_O[31:3] == '0)
    else $error("control upper bits set");
  status_upper_a: assert property (rda && AVS_ADDRESS_I == REG_STATUS |->
    AVS_READDATA_O[31:6] == '0) else $error("status upper bits set");
  result_code_a: assert property (rda && AVS_ADDRESS_I == REG_RESULT |->
    AVS_READDATA_O <= 32'h0000_0003) else $error("result code out of range");
  data_stands_a: assert property (!req |=> $stable(AVS_READDATA_O))
    else $error("read data moved while idle");
  idle_gap_a: assert property (ans |=> !req || AVS_WAITREQUEST_O)
    else $error("no idle cycle after answer");
endmodule : scss_checker
bind scss_top scss_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_RESPONSE_ERR_O(AVS_RESPONSE_ERR_O));

// ---- tb/scss_term.sv ----
// terminal model: register master that issues card commands
`timescale 1ns/1ns
module scss_term
  import scss_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        err_i,
  output scss_bus_req_s    bus_o
);
  initial bus_o = '0;
  // held until wait seen low, then released with scrambled lines
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    bus_o <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge clk_i);
    while (wait_i !== 1'b0) @(posedge clk_i);
    q = rdata_i;
    e = err_i;
    bus_o <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
  endtask : xfer
endmodule : scss_term

// ---- tb/subscriber_card_session_sequencer_test.sv ----
// testbench: session sequencer against a reference model
`timescale 1ns/1ns
module subscriber_card_session_sequencer_test
  import scss_pkg::*;
;
  logic          clk;
  logic          rst_n;
  scss_bus_req_s bus;
  logic [31:0]   rdata;
  logic          wreq;
  logic          err;
  logic [31:0]   q;
  logic [2:0]    m_ctrl = '0;
  int            n_fail = 0, cmp_count = 0, m_res;
  int            m_id = 1, m_loc = 1, m_cc = 0, m_fdn = 0, m_seen = 0, m_pend = 0, m_poll = 30;
  int            m_data = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  scss_top uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(bus.address),
    .AVS_READ_I(bus.read), .AVS_WRITE_I(bus.write), .AVS_WRITEDATA_I(bus.writedata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .AVS_RESPONSE_ERR_O(err));
  scss_term term (.clk_i(clk), .wait_i(wreq), .rdata_i(rdata), .err_i(err), .bus_o(bus));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic io(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic e;
    term.xfer(wr, a, d, q, e);
    chk("err", {31'h0, a[1:0] != 2'b00}, {31'h0, e});
  endtask : io
  task automatic cmd(input logic [2:0] k, input logic [7:0] a);
    if (m_pend) begin
      m_id = 0;
      m_loc = 0;
      m_pend = 0;
    end
    m_res = RES_OK;
    case (k)
      REQ_SELECT: m_pend = m_ctrl[CTRL_USES_DN] && (a == FILE_IDENT || a == FILE_LOC);
      REQ_READ: begin
        m_data = a;
        if ((a == FILE_IDENT && !m_id) || (a == FILE_LOC && !m_loc)) begin
          m_res = RES_ACCESS_ERR;
          m_data = 0;
        end
      end
      REQ_PROFILE: begin
        m_seen = 1;
        m_fdn = a[PROF_FDN];
        m_cc = a[PROF_CC];
      end
      REQ_REHAB: if (m_ctrl[CTRL_BDN_EN] && !(m_seen && m_cc)) m_res = RES_REHAB_ERR;
        else begin
          m_id = 1;
          m_loc = 1;
        end
      REQ_STATUS: begin
        m_data = m_poll;
        if (a != 0) m_poll = a;
      end
      default: m_res = RES_BAD_REQ;
    endcase
    io(1'b1, REG_REQ, {20'h0, a, 1'b0, k});
    io(1'b0, REG_RESULT, '0);
    chk("result", 32'(m_res), q);
    io(1'b0, REG_STATUS, '0);
    chk("status", 32'(m_id | m_loc << 1 | m_cc << 2 | m_fdn << 3 | m_seen << 4 | m_pend << 5),
        q);
    io(1'b0, REG_REQ, '0);
    chk("poll", 32'(m_poll), {24'h0, q[15:8]});
    chk("data", 32'(m_data), {24'h0, q[7:0]});
    if (m_res == 1) chk("denied data", '0, {24'h0, q[7:0]});
  endtask : cmd
  // terminal start-up, polling and shutdown in order
  task automatic session();
    cmd(REQ_SELECT, 8'h10);
    cmd(REQ_READ, 8'h11);
    cmd(REQ_READ, 8'h12);
    cmd(REQ_READ, 8'h13);
    cmd(REQ_READ, 8'h14);
    cmd(REQ_PROFILE, 8'h03);
    cmd(REQ_REHAB, FILE_IDENT);
    for (int f = 32; f < 38; f++) cmd(REQ_READ, 8'(f));
    cmd(REQ_READ, FILE_IDENT);
    cmd(REQ_READ, FILE_LOC);
    for (int p = 0; p < 3; p++) begin
      repeat (m_poll) @(posedge clk);
      cmd(REQ_STATUS, 8'h00);
    end
    cmd(REQ_SELECT, FILE_LOC);
    cmd(REQ_READ, FILE_LOC);
    cmd(REQ_STATUS, 8'h00);
  endtask : session
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    void'($urandom(67));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    io(1'b0, REG_CTRL, '0);
    chk("ctrl reset", 32'(CTRL_RESET), q);
    io(1'b1, REG_STATUS, '1);
    io(1'b1, 4'h6, '1);
    io(1'b0, 4'h2, '0);
    chk("unmapped data", '0, q);
    cmd(3'h6, 8'h00);
    cmd(3'h7, 8'h00);
    cmd(REQ_SELECT, FILE_IDENT);
    cmd(REQ_STATUS, 8'h0A);
    cmd(REQ_STATUS, 8'h00);
    session();
    for (int i = 0; i < 16; i++) begin
      m_ctrl = 3'($urandom);
      io(1'b1, REG_CTRL, 32'(m_ctrl));
      io(1'b0, REG_CTRL, '0);
      chk("ctrl", 32'(m_ctrl), q);
      if ($urandom % 2) cmd(REQ_PROFILE, 8'($urandom % 4));
      cmd(REQ_SELECT, 8'(1 + $urandom % 2));
      cmd(REQ_READ, FILE_IDENT);
      cmd(REQ_REHAB, FILE_IDENT);
      cmd(REQ_REHAB, FILE_LOC);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    m_ctrl = '0;
    m_id = 1;
    m_loc = 1;
    m_cc = 0;
    m_fdn = 0;
    m_seen = 0;
    m_pend = 0;
    m_poll = 30;
    m_data = 0;
    io(1'b0, REG_CTRL, '0);
    chk("ctrl after reset", 32'(CTRL_RESET), q);
    m_ctrl = 3'h7;
    io(1'b1, REG_CTRL, 32'(m_ctrl));
    session();
    test_done();
  end
endmodule : subscriber_card_session_sequencer_test
